//--- hdl/bank_pkg.sv
package bank_pkg;
    localparam int unsigned NUM_GPR   = 31;
    localparam int unsigned NUM_SAVED = 5;
    localparam logic [3:0] IDX_SHARED_LAST = 4'h7;
    localparam logic [3:0] IDX_FAST_LAST   = 4'hc;
    localparam logic [3:0] IDX_SP          = 4'hd;
    localparam logic [3:0] IDX_LINK        = 4'he;
    localparam logic [3:0] IDX_PC          = 4'hf;
    // physical slots of the pc and of the banked copies
    localparam logic [4:0] PHYS_PC    = 5'h0f;
    localparam logic [4:0] PHYS_FAST  = 5'h10;
    localparam logic [4:0] PHYS_SUPV  = 5'h17;
    localparam logic [4:0] PHYS_ABT   = 5'h19;
    localparam logic [4:0] PHYS_UND   = 5'h1b;
    localparam logic [4:0] PHYS_IRQ   = 5'h1d;
    typedef enum logic [4:0] {
        MODE_USER   = 5'h10,
        MODE_FAST   = 5'h11,
        MODE_IRQ    = 5'h12,
        MODE_SUPV   = 5'h13,
        MODE_ABORT  = 5'h17,
        MODE_UNDEF  = 5'h1b,
        MODE_SYSTEM = 5'h1f
    } mode_type;
    // status word fields
    localparam int unsigned BIT_N = 31;
    localparam int unsigned BIT_Z = 30;
    localparam int unsigned BIT_C = 29;
    localparam int unsigned BIT_V = 28;
    localparam int unsigned BIT_IRQ_OFF  = 7;
    localparam int unsigned BIT_FAST_OFF = 6;
    localparam int unsigned BIT_STATE    = 5;
    localparam logic [31:0] STATUS_MASK  = 32'hf00000ff;
    localparam logic [31:0] STATUS_RESET = 32'h000000d3;
    // saved status slots; none for user and system
    localparam logic [2:0] SAVED_FAST = 3'h0;
    localparam logic [2:0] SAVED_IRQ  = 3'h1;
    localparam logic [2:0] SAVED_SUPV = 3'h2;
    localparam logic [2:0] SAVED_ABT  = 3'h3;
    localparam logic [2:0] SAVED_UND  = 3'h4;
    localparam logic [2:0] SAVED_NONE = 3'h7;
    // pending bits, also priority order low index first
    localparam int unsigned PEND_ABORT = 0;
    localparam int unsigned PEND_FAST  = 1;
    localparam int unsigned PEND_IRQ   = 2;
    localparam int unsigned PEND_UNDEF = 3;
    localparam int unsigned PEND_TRAP  = 4;
    localparam logic [31:0] VEC_UNDEF = 32'h00000004;
    localparam logic [31:0] VEC_TRAP  = 32'h00000008;
    localparam logic [31:0] VEC_ABORT = 32'h00000010;
    localparam logic [31:0] VEC_IRQ   = 32'h00000018;
    localparam logic [31:0] VEC_FAST  = 32'h0000001c;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [3:0] WB_STATUS = 4'h0;
    localparam logic [3:0] WB_SAVED  = 4'h4;
    localparam logic [3:0] WB_PEND   = 4'h8;
    localparam logic [3:0] WB_INFO   = 4'hc;

    function automatic logic mode_valid(input logic [4:0] m);
        mode_valid = (m == MODE_USER) || (m == MODE_FAST) || (m == MODE_IRQ) ||
                     (m == MODE_SUPV) || (m == MODE_ABORT) || (m == MODE_UNDEF) ||
                     (m == MODE_SYSTEM);
    endfunction

    function automatic logic [4:0] phys_index(input logic [4:0] m, input logic [3:0] idx);
        phys_index = {1'b0, idx};
        if (idx > IDX_SHARED_LAST && idx != IDX_PC)
        begin
            case (m)
                MODE_FAST:  phys_index = 5'(PHYS_FAST + 5'(idx - 4'h8));
                MODE_SUPV:  if (idx >= IDX_SP) phys_index = 5'(PHYS_SUPV + 5'(idx - IDX_SP));
                MODE_ABORT: if (idx >= IDX_SP) phys_index = 5'(PHYS_ABT + 5'(idx - IDX_SP));
                MODE_UNDEF: if (idx >= IDX_SP) phys_index = 5'(PHYS_UND + 5'(idx - IDX_SP));
                MODE_IRQ:   if (idx >= IDX_SP) phys_index = 5'(PHYS_IRQ + 5'(idx - IDX_SP));
                default:    phys_index = {1'b0, idx};
            endcase
        end
    endfunction

    function automatic logic [2:0] saved_index(input logic [4:0] m);
        case (m)
            MODE_FAST:  saved_index = SAVED_FAST;
            MODE_IRQ:   saved_index = SAVED_IRQ;
            MODE_SUPV:  saved_index = SAVED_SUPV;
            MODE_ABORT: saved_index = SAVED_ABT;
            MODE_UNDEF: saved_index = SAVED_UND;
            default:    saved_index = SAVED_NONE;
        endcase
    endfunction
endpackage

//--- hdl/cond_eval.sv
`timescale 1ns/10ps
`default_nettype none
module cond_eval (
    input  wire logic [3:0] cond_i,  // condition field
    input  wire logic [3:0] flags_i, // n z c v
    output logic            pass_o   // condition holds
);
    logic n, z, c, v;
    assign {n, z, c, v} = flags_i;
    always_comb
    begin
        case (cond_i)
            4'h0: pass_o = z;
            4'h1: pass_o = !z;
            4'h2: pass_o = c;
            4'h3: pass_o = !c;
            4'h4: pass_o = n;
            4'h5: pass_o = !n;
            4'h6: pass_o = v;
            4'h7: pass_o = !v;
            4'h8: pass_o = c && !z;
            4'h9: pass_o = !c || z;
            4'ha: pass_o = n == v;
            4'hb: pass_o = n != v;
            4'hc: pass_o = !z && (n == v);
            4'hd: pass_o = z || (n != v);
            4'he: pass_o = 1'b1;
            // reserved code never executes
            default: pass_o = 1'b0;
        endcase
    end
endmodule // cond_eval
`default_nettype wire

//--- hdl/banked_register_mode_unit.sv
`timescale 1ns/10ps
`default_nettype none
module banked_register_mode_unit (
    input  wire logic        clk_i,          // core clock
    input  wire logic        rst_i,          // sync reset, high
    input  wire logic        wb_cyc_i,       // bus cycle
    input  wire logic        wb_stb_i,       // bus strobe
    input  wire logic        wb_we_i,        // bus write
    input  wire logic [3:0]  wb_adr_i,       // byte address
    input  wire logic [3:0]  wb_sel_i,       // byte lanes
    input  wire logic [31:0] wb_dat_i,       // write data
    output logic [31:0]      wb_dat_o,       // read data
    output logic             wb_ack_o,       // bus ack
    input  wire logic [3:0]  rd_a_idx_i,     // read port a index
    input  wire logic [3:0]  rd_b_idx_i,     // read port b index
    output logic [31:0]      rd_a_data_o,    // read port a data
    output logic [31:0]      rd_b_data_o,    // read port b data
    input  wire logic        wr_en_i,        // register write
    input  wire logic [3:0]  wr_idx_i,       // write index
    input  wire logic [31:0] wr_data_i,      // write data
    input  wire logic        call_i,         // subroutine call
    input  wire logic [31:0] call_ret_i,     // return address
    input  wire logic        pc_we_i,        // pc update
    input  wire logic [31:0] pc_next_i,      // new pc
    input  wire logic        flags_we_i,     // flag update
    input  wire logic [3:0]  flags_i,        // new n z c v
    input  wire logic [31:0] instr_i,        // full-width instruction
    input  wire logic [1:0]  acc_size_i,     // access size
    input  wire logic [31:0] acc_addr_i,     // access address
    input  wire logic        fast_req_i,     // fast interrupt level
    input  wire logic        irq_req_i,      // normal interrupt level
    input  wire logic        abort_i,        // memory abort pulse
    input  wire logic        undef_i,        // undefined instr pulse
    input  wire logic        trap_i,         // software trap pulse
    input  wire logic        ret_dp_i,       // flag-setting op to pc
    input  wire logic        ret_ldm_i,      // load_multiple_restore
    output logic [31:0]      pc_o,           // program counter
    output logic [31:0]      status_o,       // current_status_word
    output logic             privileged_o,   // non-user mode
    output logic             compact_o,      // 16-bit state
    output logic             cond_ok_o,      // instruction executes
    output logic             align_fault_o,  // misaligned access
    output logic             exc_taken_o     // entry pulse
);
    typedef struct packed {
        logic [bank_pkg::NUM_GPR-1:0][31:0]   regs;
        logic [31:0]                          status;
        logic [bank_pkg::NUM_SAVED-1:0][31:0] saved;
        logic [4:0]                           pend;
        logic [31:0]                          rd_a;
        logic [31:0]                          rd_b;
        logic                                 priv;
        logic                                 cond_ok;
        logic                                 align_fault;
        logic                                 taken;
        logic                                 ack;
        logic [31:0]                          dat;
    } state_type;

    state_type q, d;
    logic       cond_pass;
    logic [4:0] mode;
    logic [4:0] req;
    logic [2:0] sv_idx;
    logic       bus_req;

    assign mode    = q.status[4:0];
    assign sv_idx  = bank_pkg::saved_index(mode);
    assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;

    cond_eval u_cond (
        .cond_i  (instr_i[31:28]),
        .flags_i (q.status[31:28]),
        .pass_o  (cond_pass)
    );

    // interrupts are levels gated by their masks; the rest are latched
    always_comb
    begin
        req = q.pend;
        req[bank_pkg::PEND_ABORT] = q.pend[bank_pkg::PEND_ABORT] | abort_i;
        req[bank_pkg::PEND_UNDEF] = q.pend[bank_pkg::PEND_UNDEF] | undef_i;
        req[bank_pkg::PEND_TRAP]  = q.pend[bank_pkg::PEND_TRAP] | trap_i;
        req[bank_pkg::PEND_FAST]  = fast_req_i && !q.status[bank_pkg::BIT_FAST_OFF];
        req[bank_pkg::PEND_IRQ]   = irq_req_i && !q.status[bank_pkg::BIT_IRQ_OFF];
    end

    always_comb
    begin
        logic [4:0]  new_mode;
        logic [31:0] vec;
        logic [2:0]  tgt_sv;
        logic [4:0]  lnk;
        logic [31:0] wdat;
        logic        take;
        logic [4:0]  win;
        new_mode = mode;
        vec      = bank_pkg::VEC_UNDEF;
        tgt_sv   = bank_pkg::SAVED_NONE;
        lnk      = 5'h00;
        wdat     = 32'h00000000;
        take     = 1'b0;
        win      = 5'h00;
        d        = q;
        d.taken  = 1'b0;
        d.ack    = bus_req;
        d.pend   = req;

        // fixed priority: abort, fast, irq, undefined, trap
        if (req[bank_pkg::PEND_ABORT])
        begin
            win[bank_pkg::PEND_ABORT] = 1'b1;
            new_mode = bank_pkg::MODE_ABORT;
            vec = bank_pkg::VEC_ABORT;
        end
        else if (req[bank_pkg::PEND_FAST])
        begin
            win[bank_pkg::PEND_FAST] = 1'b1;
            new_mode = bank_pkg::MODE_FAST;
            vec = bank_pkg::VEC_FAST;
        end
        else if (req[bank_pkg::PEND_IRQ])
        begin
            win[bank_pkg::PEND_IRQ] = 1'b1;
            new_mode = bank_pkg::MODE_IRQ;
            vec = bank_pkg::VEC_IRQ;
        end
        else if (req[bank_pkg::PEND_UNDEF])
        begin
            win[bank_pkg::PEND_UNDEF] = 1'b1;
            new_mode = bank_pkg::MODE_UNDEF;
            vec = bank_pkg::VEC_UNDEF;
        end
        else if (req[bank_pkg::PEND_TRAP])
        begin
            win[bank_pkg::PEND_TRAP] = 1'b1;
            new_mode = bank_pkg::MODE_SUPV;
            vec = bank_pkg::VEC_TRAP;
        end
        take = |win;

        // ordinary core writes first, so entry or return below overrides them
        if (wr_en_i && wr_idx_i != bank_pkg::IDX_PC)
            d.regs[bank_pkg::phys_index(mode, wr_idx_i)] = wr_data_i;
        if (call_i)
            d.regs[bank_pkg::phys_index(mode, bank_pkg::IDX_LINK)] = call_ret_i;
        if (pc_we_i)
            d.regs[bank_pkg::PHYS_PC] = pc_next_i;
        if (flags_we_i)
            d.status[31:28] = flags_i;

        // software status write, ignored for invalid mode codes
        if (bus_req && wb_we_i && wb_adr_i == bank_pkg::WB_STATUS && wb_sel_i[0])
        begin
            wdat = (wb_dat_i & bank_pkg::STATUS_MASK);
            if (!wb_sel_i[3])
                wdat[31:28] = q.status[31:28];
            if (bank_pkg::mode_valid(wdat[4:0]) && q.priv)
                d.status = wdat;
        end
        if (bus_req && wb_we_i && wb_adr_i == bank_pkg::WB_SAVED && sv_idx != bank_pkg::SAVED_NONE)
            d.saved[sv_idx] = wb_dat_i & bank_pkg::STATUS_MASK;

        // return: system and user have no saved word, so nothing happens there
        if ((ret_dp_i || ret_ldm_i) && sv_idx != bank_pkg::SAVED_NONE && !take)
        begin
            d.status = q.saved[sv_idx];
            d.regs[bank_pkg::PHYS_PC] = q.regs[bank_pkg::phys_index(mode, bank_pkg::IDX_LINK)];
        end

        if (take)
        begin
            tgt_sv = bank_pkg::saved_index(new_mode);
            lnk    = bank_pkg::phys_index(new_mode, bank_pkg::IDX_LINK);
            d.saved[tgt_sv] = q.status;
            d.regs[lnk] = q.regs[bank_pkg::PHYS_PC];
            d.regs[bank_pkg::PHYS_PC] = vec;
            d.status[4:0] = new_mode;
            d.status[bank_pkg::BIT_STATE] = 1'b0;
            d.status[bank_pkg::BIT_IRQ_OFF] = 1'b1;
            if (new_mode == bank_pkg::MODE_FAST)
                d.status[bank_pkg::BIT_FAST_OFF] = 1'b1;
            d.pend  = req & ~win;
            d.taken = 1'b1;
        end

        // sixteen visible through the mode map; pc read through slot 15
        d.rd_a = q.regs[bank_pkg::phys_index(mode, rd_a_idx_i)];
        d.rd_b = q.regs[bank_pkg::phys_index(mode, rd_b_idx_i)];
        d.priv = d.status[4:0] != bank_pkg::MODE_USER;
        d.cond_ok = cond_pass && !d.status[bank_pkg::BIT_STATE];
        case (acc_size_i)
            bank_pkg::SIZE_WORD: d.align_fault = acc_addr_i[1:0] != 2'h0;
            bank_pkg::SIZE_HALF: d.align_fault = acc_addr_i[0];
            bank_pkg::SIZE_BYTE: d.align_fault = 1'b0;
            default:             d.align_fault = 1'b1;
        endcase

        d.dat = 32'h00000000;
        if (bus_req && !wb_we_i)
        begin
            case (wb_adr_i)
                bank_pkg::WB_STATUS: d.dat = q.status;
                bank_pkg::WB_SAVED:  d.dat = (sv_idx == bank_pkg::SAVED_NONE) ? 32'h00000000 :
                                             q.saved[sv_idx];
                bank_pkg::WB_PEND:   d.dat = {27'h0000000, q.pend};
                bank_pkg::WB_INFO:   d.dat = {30'h00000000, q.status[bank_pkg::BIT_STATE],
                                             q.priv};
                default:             d.dat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q        <= '0;
            q.status <= bank_pkg::STATUS_RESET;
            q.priv   <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign wb_dat_o      = q.dat;
    assign wb_ack_o      = q.ack;
    assign rd_a_data_o   = q.rd_a;
    assign rd_b_data_o   = q.rd_b;
    assign pc_o          = q.regs[bank_pkg::PHYS_PC];
    assign status_o      = q.status;
    assign privileged_o  = q.priv;
    assign compact_o     = q.status[bank_pkg::BIT_STATE];
    assign cond_ok_o     = q.cond_ok;
    assign align_fault_o = q.align_fault;
    assign exc_taken_o   = q.taken;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_word_align: assert property (acc_size_i == bank_pkg::SIZE_WORD && acc_addr_i[1:0] != 2'h0
        |=> align_fault_o) else $error("misaligned word not flagged");
    chk_mode_legal: assert property (bank_pkg::mode_valid(status_o[4:0]))
        else $error("illegal mode code");
    chk_priv_flag: assert property (##1 privileged_o == (status_o[4:0] != bank_pkg::MODE_USER))
        else $error("privilege flag wrong");
    chk_entry_saved: assert property (exc_taken_o |->
        q.saved[bank_pkg::saved_index(status_o[4:0])] == $past(status_o))
        else $error("entry did not save status");
    chk_entry_link: assert property (exc_taken_o |->
        q.regs[bank_pkg::phys_index(status_o[4:0], bank_pkg::IDX_LINK)] == $past(pc_o))
        else $error("entry link wrong");
    chk_abort_first: assert property (abort_i |=> exc_taken_o && status_o[4:0] == bank_pkg::MODE_ABORT)
        else $error("abort not taken first");
    chk_trap_kept: assert property (trap_i && (abort_i || undef_i) |=>
        q.pend[bank_pkg::PEND_TRAP] ##1
        q.pend[bank_pkg::PEND_TRAP] || status_o[4:0] == bank_pkg::MODE_SUPV)
        else $error("trap request lost");
    chk_return_status: assert property ((ret_dp_i || ret_ldm_i) && sv_idx != bank_pkg::SAVED_NONE &&
        req == 5'h00 |=> status_o == $past(q.saved[sv_idx]))
        else $error("return did not restore");
    chk_shared_low: assert property (rd_a_idx_i <= bank_pkg::IDX_SHARED_LAST |=>
        rd_a_data_o == $past(q.regs[rd_a_idx_i]))
        else $error("low register not shared");
    chk_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack timing");
    cov_fast_entry: cover property (exc_taken_o && status_o[4:0] == bank_pkg::MODE_FAST);
    cov_double_req: cover property ((abort_i || undef_i) && trap_i ##1 exc_taken_o ##1 exc_taken_o);
    cov_return: cover property (ret_dp_i && sv_idx != bank_pkg::SAVED_NONE);
    cov_sys_write: cover property (wb_ack_o && status_o[4:0] == bank_pkg::MODE_SYSTEM);
endmodule // banked_register_mode_unit
`default_nettype wire

//--- verif/exc_source.sv
`timescale 1ns/10ps
`default_nettype none
module exc_source (
    input  wire logic       clk_i,    // core clock
    input  wire logic       rst_i,    // sync reset, high
    input  wire logic [2:0] raise_i,  // raise fast, irq, abort
    input  wire logic [1:0] drop_i,   // release fast, irq
    output logic            fast_o,   // fast interrupt level
    output logic            irq_o,    // normal interrupt level
    output logic            abort_o   // memory abort pulse
);
    // levels hold until the handler clears its source, as a real controller does
    always_ff @(posedge clk_i)
    begin
        fast_o  <= !rst_i && (raise_i[2] || (fast_o && !drop_i[1]));
        irq_o   <= !rst_i && (raise_i[1] || (irq_o && !drop_i[0]));
        abort_o <= !rst_i && raise_i[0];
    end
endmodule // exc_source
`default_nettype wire

//--- verif/banked_register_mode_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module banked_register_mode_unit_tb;
    typedef struct packed {
        logic [31:0] st;
        logic [3:0]  idx;
        logic [31:0] exp;
    } row_type;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wr_en_i, call_i, pc_we_i;
    logic        flags_we_i, fast_req_i, irq_req_i, abort_i, undef_i, trap_i, ret_dp_i, ret_ldm_i;
    logic        privileged_o, compact_o, cond_ok_o, align_fault_o, exc_taken_o;
    logic [3:0]  wb_adr_i, wb_sel_i, rd_a_idx_i, rd_b_idx_i, wr_idx_i, flags_i;
    logic [1:0]  acc_size_i, drop;
    logic [2:0]  raise;
    logic [31:0] wb_dat_i, wb_dat_o, rd_a_data_o, rd_b_data_o, wr_data_i, call_ret_i, pc_next_i;
    logic [31:0] instr_i, acc_addr_i, pc_o, status_o, q;
    int          num_errors = 0;
    int          compares = 0;
    int          i;
    row_type     rows [9] = '{'{32'hd3, 4'hd, 32'h10d}, '{32'hd3, 4'h8, 32'h208},
        '{32'hdf, 4'hd, 32'h20d}, '{32'hd1, 4'h3, 32'h103}, '{32'hd1, 4'h8, 32'h0},
        '{32'hd1, 4'hc, 32'h0}, '{32'hd2, 4'hc, 32'h20c}, '{32'hd2, 4'he, 32'h0},
        '{32'hd7, 4'h7, 32'h107}};
    // {cond, executes} and {size, addr[1:0], fault}
    logic [4:0]  conds [4] = '{5'h01, 5'h02, 5'h1d, 5'h1e};
    logic [4:0]  aligns [6] = '{5'h10, 5'h15, 5'h0c, 5'h0b, 5'h06, 5'h19};

    banked_register_mode_unit dut (.*);
    exc_source far (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise), .drop_i(drop),
        .fast_o(fast_req_i), .irq_o(irq_req_i), .abort_o(abort_i));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic results();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= d;
        // only the watchdog ends a wait for the answer
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    task automatic wst(input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, 4'h0, d, r);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        @(posedge clk_i);
        rd_a_idx_i <= idx;
        rd_b_idx_i <= idx;
        settle();
        chk(rd_a_data_o, exp);
        chk(rd_b_data_o, exp);
    endtask

    // entry pulse may already stand when called, so look before waiting
    task automatic wexc(input logic [4:0] mode, input logic [31:0] vec);
        int n;
        for (n = 0; n < 10; n++)
        begin
            #1;
            if (exc_taken_o === 1'b1)
                break;
            @(posedge clk_i);
        end
        chk({31'h0, exc_taken_o}, 32'h1);
        chk({27'h0, status_o[4:0]}, {27'h0, mode});
        chk(pc_o, vec);
        @(posedge clk_i);
    endtask

    task automatic leave(input logic load_multiple_restore, input logic [31:0] st, input logic [31:0] p);
        @(posedge clk_i);
        {ret_ldm_i, ret_dp_i} <= {load_multiple_restore, !load_multiple_restore};
        @(posedge clk_i);
        {ret_ldm_i, ret_dp_i} <= 2'b00;
        settle();
        chk(status_o, st);
        chk(pc_o, p);
    endtask

    initial
    begin
        {rst_i, wb_sel_i} = {1'b1, 4'hf};
        {wb_cyc_i, wb_stb_i, wb_we_i, wr_en_i, call_i, pc_we_i, flags_we_i, undef_i, trap_i} = '0;
        {ret_dp_i, ret_ldm_i, raise, drop, wb_adr_i, rd_a_idx_i, rd_b_idx_i, wr_idx_i} = '0;
        {flags_i, acc_size_i, wb_dat_i, wr_data_i, call_ret_i, pc_next_i, instr_i, acc_addr_i} = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk(status_o, 32'h000000d3);
        chk({31'h0, privileged_o}, 32'h1);
        for (i = 0; i < 22; i++)
        begin
            if (i == 15)
                wst(32'h000000df);
            @(posedge clk_i);
            wr_en_i   <= 1'b1;
            wr_idx_i  <= (i < 15) ? 4'(i) : 4'(i - 7);
            wr_data_i <= (i < 15) ? 32'h100 + i : 32'h200 + i - 7;
            @(posedge clk_i);
            wr_en_i <= 1'b0;
        end
        foreach (rows[k])
        begin
            wst(rows[k].st);
            rd(rows[k].idx, rows[k].exp);
        end
        wst(32'h0000001f);
        @(posedge clk_i);
        {call_i, pc_we_i, flags_we_i} <= 3'b111;
        {call_ret_i, pc_next_i, flags_i} <= {32'h12345678, 32'h00000040, 4'h4};
        @(posedge clk_i);
        {call_i, pc_we_i, flags_we_i} <= 3'b000;
        rd(4'he, 32'h12345678);
        rd(4'hf, 32'h00000040);
        chk(status_o, 32'h4000001f);
        foreach (conds[k])
        begin
            @(posedge clk_i);
            instr_i <= {conds[k][4:1], 28'h0};
            settle();
            chk({31'h0, cond_ok_o}, {31'h0, conds[k][0]});
        end
        foreach (aligns[k])
        begin
            @(posedge clk_i);
            {acc_size_i, acc_addr_i} <= {aligns[k][4:3], 30'h0, aligns[k][2:1]};
            settle();
            chk({31'h0, align_fault_o}, {31'h0, aligns[k][0]});
        end
        // three requests in one cycle: abort, then fast, irq left masked
        @(posedge clk_i);
        raise <= 3'b111;
        @(posedge clk_i);
        raise <= 3'b000;
        wexc(5'h17, 32'h00000010);
        wexc(5'h11, 32'h0000001c);
        drop <= 2'b11;
        rd(4'he, 32'h00000010);
        wb(1'b0, 4'h4, 32'h0, q);
        chk(q, 32'h40000097);
        leave(1'b0, 32'h40000097, 32'h00000010);
        rd(4'he, 32'h00000040);
        wb(1'b0, 4'h4, 32'h0, q);
        chk(q, 32'h4000001f);
        leave(1'b1, 32'h4000001f, 32'h00000040);
        wb(1'b0, 4'h4, 32'h0, q);
        chk(q, 32'h0);
        @(posedge clk_i);
        {undef_i, trap_i} <= 2'b11;
        @(posedge clk_i);
        {undef_i, trap_i} <= 2'b00;
        wexc(5'h1b, 32'h00000004);
        wexc(5'h13, 32'h00000008);
        wb(1'b0, 4'h8, 32'h0, q);
        chk(q, 32'h0);
        wst(32'h000000ff);
        instr_i <= 32'he0000000;
        settle();
        chk({30'h0, compact_o, cond_ok_o}, 32'h2);
        wb(1'b0, 4'hc, 32'h0, q);
        chk(q, 32'h3);
        wst(32'h000000d5);
        chk(status_o, 32'h000000ff);
        wst(32'h00000010);
        settle();
        chk({31'h0, privileged_o}, 32'h0);
        wst(32'h0000001f);
        chk(status_o, 32'h00000010);
        // second reset in mid-run, from user mode
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk(status_o, 32'h000000d3);
        chk({31'h0, privileged_o}, 32'h1);
        chk(pc_o, 32'h0);
        wb(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0);
        results();
    end

    initial
    begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        results();
    end
endmodule // banked_register_mode_unit_tb
`default_nettype wire
